/* shared/rst_ctrl_pkg.sv */
package rst_ctrl_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] UVC_OFF = 12'h000;
  localparam logic [11:0] RCF_OFF = 12'h004;
  localparam logic [11:0] WDC_OFF = 12'h008;
  localparam logic [11:0] STS_OFF = 12'h00c;
  localparam logic [11:0] CMD_OFF = 12'h010;
  // ==========================================================================
  // Keys and reset values
  localparam logic [7:0] UV_KEY_ON = 8'h5a;
  localparam logic [7:0] UV_KEY_OFF = 8'ha5;
  localparam logic [7:0] UV_CTRL_RST = 8'h5a;
  localparam logic [4:0] WD_KEY_ON = 5'h0a;
  localparam logic [4:0] WD_KEY_OFF = 5'h15;
  localparam logic [7:0] WD_CTRL_RST = 8'h57;
  // Reset-cause bit positions.
  localparam int UV_EVT_BIT = 2;
  localparam int UV_KF_BIT = 1;
  localparam int WD_KF_BIT = 0;
  // Status bit positions.
  localparam int TO_BIT = 0;
  localparam int PD_BIT = 1;
  // Command bit positions.
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_CLRWDT_BIT = 1;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int KEY_FAULT_DELAY_NS = 200;
  localparam int UV_FILTER_NS = 120;
  localparam int KEY_FAULT_CYC = KEY_FAULT_DELAY_NS / CLK_PERIOD_NS;
  localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = 4;
  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {MODE_FAST, MODE_SLOW, MODE_IDLE, MODE_SLEEP} mode_t;
endpackage : rst_ctrl_pkg

/* hdl/reset_cause_and_undervolt_ctrl.sv */
`timescale 1ns/10ps
// Behaviour
// - Power-on reset clears the program counter to zero.
// - Power-on reset sets port data and direction registers to all ones.
// - Undervoltage resets only after low supply outlasts the filter time.
// - Qualified undervoltage reset sets the undervoltage event flag.
// - Key 5a enables undervoltage reset, key a5 disables it.
// - Other undervoltage keys reset after delay and restore power-on key.
// - Invalid undervoltage key sets the undervoltage key fault flag.
// - Genuine undervoltage reset keeps the undervoltage control register.
// - Undervoltage key holds 5a after power-on, reset enabled.
// - Undervoltage reset is disabled in idle or sleep mode.
// - Event and key fault flags are set by hardware, cleared by software.
// - Reset-cause bits seven to three read as zero.
// - Watchdog timeout in fast or slow causes full reset, sets timeout.
// - Watchdog timeout in sleep or idle clears only PC and stack.
// - Timeout and power-down flag values follow the reset type.
// - Power-on reset disables all interrupts.
// - Power-on reset clears watchdog and time base; watchdog then counts.
// - Power-on reset switches the timer/event counter off.
// - Power-on reset points the stack pointer at the stack top.
// - Watchdog key 15 disables, 0a enables, others reset and flag fault.
// - Halt sets power-down; power-up or clear-watchdog clears it.
module reset_cause_and_undervolt_ctrl
  import rst_ctrl_pkg::*;
#(
  parameter int FILTER_CYC = rst_ctrl_pkg::UV_FILTER_CYC,
  parameter int FAULT_CYC = rst_ctrl_pkg::KEY_FAULT_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitor and core events
  input wire logic low_supply,
  input wire logic wdog_overflow,
  input wire logic [1:0] cpu_mode,
  // Reset and watchdog outputs
  output logic sys_reset,
  output logic pc_sp_reset,
  output logic por_init,
  output logic wdog_enable,
  output logic [2:0] wdog_period
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] uvc;
    logic [7:0] wdc;
    logic uv_evt;
    logic uv_kf;
    logic wd_kf;
    logic to_flag;
    logic pd_flag;
    logic [15:0] uv_cnt;
    logic [15:0] kf_cnt;
    logic kf_pend;
    logic [3:0] rst_cnt;
    logic full_rst;
    logic pcsp;
    logic por;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic wr;
  logic rd;
  logic uv_key_bad;
  logic wd_key_bad;
  logic low_power;
  logic uv_armed;
  logic uv_fire;
  logic kf_fire;
  logic wd_full;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign uv_key_bad = (st_reg.uvc != UV_KEY_ON) && (st_reg.uvc != UV_KEY_OFF);
  assign wd_key_bad = (st_reg.wdc[7:3] != WD_KEY_ON) && (st_reg.wdc[7:3] != WD_KEY_OFF);
  assign low_power = (cpu_mode == MODE_IDLE) || (cpu_mode == MODE_SLEEP);
  assign uv_armed = (st_reg.uvc == UV_KEY_ON) && !low_power;
  assign uv_fire = uv_armed && low_supply && (st_reg.uv_cnt == 16'(FILTER_CYC));
  assign kf_fire = st_reg.kf_pend && (st_reg.kf_cnt == 16'(FAULT_CYC));
  assign wd_full = wdog_overflow && !low_power && (st_reg.wdc[7:3] != WD_KEY_OFF);

  always_comb begin
    st_next = st_reg;
    st_next.por = 1'b0;
    st_next.pcsp = 1'b0;
    // Filter counter restarts whenever the supply recovers.
    if (uv_armed && low_supply) begin
      if (st_reg.uv_cnt != 16'(FILTER_CYC)) begin
        st_next.uv_cnt = st_reg.uv_cnt + 16'h0001;
      end
    end else begin
      st_next.uv_cnt = 16'h0000;
    end
    if (uv_key_bad || wd_key_bad) begin
      st_next.kf_pend = 1'b1;
    end
    if (st_reg.kf_pend && !kf_fire) begin
      st_next.kf_cnt = st_reg.kf_cnt + 16'h0001;
    end
    if (wr && paddr == CMD_OFF && pwdata[CMD_CLRWDT_BIT]) begin
      st_next.pd_flag = 1'b0;
    end else if (wr && paddr == CMD_OFF && pwdata[CMD_HALT_BIT]) begin
      st_next.pd_flag = 1'b1;
    end
    if (wr && paddr == UVC_OFF) begin
      st_next.uvc = pwdata[7:0];
    end
    if (wr && paddr == WDC_OFF) begin
      st_next.wdc = pwdata[7:0];
    end
    // software clears, hardware set below wins
    if (wr && paddr == RCF_OFF) begin
      st_next.uv_evt = st_reg.uv_evt & pwdata[UV_EVT_BIT];
      st_next.uv_kf = st_reg.uv_kf & pwdata[UV_KF_BIT];
      st_next.wd_kf = st_reg.wd_kf & pwdata[WD_KF_BIT];
    end
    if (uv_fire) begin
      st_next.uv_evt = 1'b1;
      st_next.full_rst = 1'b1;
      st_next.rst_cnt = 4'(RST_PULSE_CYC);
    end
    if (kf_fire) begin
      st_next.kf_pend = 1'b0;
      st_next.kf_cnt = 16'h0000;
      st_next.full_rst = 1'b1;
      st_next.rst_cnt = 4'(RST_PULSE_CYC);
      if (uv_key_bad) begin
        st_next.uvc = UV_CTRL_RST;
        st_next.uv_kf = 1'b1;
      end
      if (wd_key_bad) begin
        st_next.wdc = WD_CTRL_RST;
        st_next.wd_kf = 1'b1;
      end
    end
    if (wd_full) begin
      st_next.to_flag = 1'b1;
      st_next.full_rst = 1'b1;
      st_next.wdc = WD_CTRL_RST;
      st_next.rst_cnt = 4'(RST_PULSE_CYC);
    end
    if (wdog_overflow && low_power && st_reg.wdc[7:3] != WD_KEY_OFF) begin
      st_next.to_flag = 1'b1;
      st_next.pd_flag = 1'b1;
      st_next.pcsp = 1'b1;
    end
    if (!(uv_fire || kf_fire || wd_full) && st_reg.full_rst) begin
      if (st_reg.rst_cnt == 4'h0) begin
        st_next.full_rst = 1'b0;
      end else begin
        st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
      end
    end
    st_next.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        UVC_OFF: st_next.rdata = {24'h000000, st_reg.uvc};
        RCF_OFF: st_next.rdata = {29'h0, st_reg.uv_evt, st_reg.uv_kf, st_reg.wd_kf};
        WDC_OFF: st_next.rdata = {24'h000000, st_reg.wdc};
        STS_OFF: st_next.rdata = {30'h0, st_reg.pd_flag, st_reg.to_flag};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end else begin
      st_next.rdata = st_reg.rdata;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // default key, flags cleared on power-on
      st_reg <= '{uvc: UV_CTRL_RST, wdc: WD_CTRL_RST, uv_evt: 1'b0, uv_kf: 1'b0,
                  wd_kf: 1'b0, to_flag: 1'b0, pd_flag: 1'b0, uv_cnt: 16'h0000,
                  kf_cnt: 16'h0000, kf_pend: 1'b0, rst_cnt: 4'(RST_PULSE_CYC),
                  full_rst: 1'b1, pcsp: 1'b0, por: 1'b1, rdata: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // The init strobe tells the core to load PC zero, stack top, ports all ones,
  // interrupts off, timer off and watchdog cleared; those registers live there.
  // power-on init
  assign por_init = st_reg.por;
  assign sys_reset = st_reg.full_rst;
  assign pc_sp_reset = st_reg.pcsp;
  assign wdog_enable = (st_reg.wdc[7:3] != WD_KEY_OFF) && !st_reg.full_rst;
  assign wdog_period = st_reg.wdc[2:0];
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================================
  // Checks
  sequence low_held_s;
    uv_armed && low_supply;
  endsequence

  uv_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_fire |=> st_reg.uv_evt && sys_reset) else $error("undervolt flag not set");
  uv_no_short_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_fire |-> $past(uv_armed && low_supply)) else $error("short dip fired");
  uv_low_pow_a: assert property (@(posedge clk) disable iff (!rst_n)
    low_power |-> !uv_fire) else $error("undervolt fired in low power");
  uv_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_fire && !kf_fire && !wr |=> $stable(st_reg.uvc)) else $error("control changed");
  uv_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire && uv_key_bad |=> st_reg.uvc == UV_CTRL_RST && st_reg.uv_kf)
    else $error("key not restored");
  rcf_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && paddr == RCF_OFF |=> prdata[31:3] == 29'h0) else $error("reserved bits set");
  to_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    wd_full |=> st_reg.to_flag && sys_reset) else $error("timeout reset missing");
  to_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_overflow && low_power && st_reg.wdc[7:3] != WD_KEY_OFF && !st_reg.full_rst
    && !uv_fire && !kf_fire |=> pc_sp_reset && st_reg.pd_flag && !sys_reset)
    else $error("idle timeout wrong");
  wd_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire && wd_key_bad |=> st_reg.wd_kf) else $error("watchdog fault flag");
  pd_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == CMD_OFF && pwdata[1:0] == 2'b01 && !wdog_overflow |=> st_reg.pd_flag)
    else $error("halt did not set flag");
  sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st_reg.uv_evt) |-> $past(wr && paddr == RCF_OFF)) else $error("flag lost");
  arm_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.uvc == UV_KEY_OFF && !st_reg.full_rst && !kf_fire && !wd_full |=> !sys_reset)
    else $error("disabled undervolt reset fired");

  // ==========================================================================
  // Power-on and filter checks
  // A key fault waits out its delay with the pending bit held, so the
  // wait is one step and the reset that ends it is another.
  sequence key_wait_s;
    st_reg.kf_pend && !kf_fire;
  endsequence

  sequence reset_start_s;
    uv_fire || kf_fire || wd_full;
  endsequence

  // These two run without a disable so that they see the reset itself.
  por_pulse_a: assert property (@(posedge clk)
    !rst_n |=> por_init) else $error("init strobe missing after reset");
  sys_hold_a: assert property (@(posedge clk)
    !rst_n |=> sys_reset) else $error("core not held in reset");
  por_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    por_init |=> !por_init) else $error("init strobe longer than one cycle");
  wd_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sys_reset) && st_reg.wdc[7:3] == WD_KEY_ON |-> wdog_enable)
    else $error("watchdog idle after reset");
  uv_cnt_max_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.uv_cnt <= 16'(FILTER_CYC)) else $error("filter counter overran");
  uv_cnt_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    !low_supply |=> st_reg.uv_cnt == 16'h0000) else $error("filter not restarted");
  uv_cnt_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    low_held_s |=> st_reg.uv_cnt != 16'h0000) else $error("filter did not count");
  uv_span_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_fire |-> $past(uv_armed && low_supply, FILTER_CYC)) else $error("dip too short");
  uv_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    low_power |=> st_reg.uv_cnt == 16'h0000) else $error("filter ran in low power");
  uv_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_fire && !wdog_overflow && !wr |=> $stable({st_reg.to_flag, st_reg.pd_flag}))
    else $error("undervolt reset changed status flags");
  reset_go_a: assert property (@(posedge clk) disable iff (!rst_n)
    reset_start_s |=> sys_reset) else $error("reset request lost");

  // ==========================================================================
  // Key fault checks
  key_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_key_bad && !kf_fire |=> st_reg.kf_pend) else $error("bad key not noticed");
  key_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    key_wait_s |=> st_reg.kf_pend) else $error("key fault wait dropped");
  key_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire |-> $past(st_reg.kf_pend, FAULT_CYC)) else $error("key fault too early");
  key_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire |=> sys_reset && !st_reg.kf_pend) else $error("key fault reset missing");
  uv_kf_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire && uv_key_bad |=> st_reg.uv_kf) else $error("undervolt key flag not set");
  wd_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
    kf_fire && wd_key_bad |=> st_reg.wdc == WD_CTRL_RST) else $error("watchdog key kept");
  wd_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.wdc[7:3] == WD_KEY_OFF |-> !wdog_enable) else $error("watchdog ran while off");

  // ==========================================================================
  // Flag checks
  // Software may clear a flag only when no event sets it in the same cycle.
  rcf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == RCF_OFF && !pwdata[UV_EVT_BIT] && !uv_fire |=> !st_reg.uv_evt)
    else $error("event flag not cleared");
  uv_kf_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st_reg.uv_kf) |-> $past(wr && paddr == RCF_OFF)) else $error("key flag lost");
  wd_kf_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st_reg.wd_kf) |-> $past(wr && paddr == RCF_OFF)) else $error("wdog flag lost");
  to_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wdog_overflow |=> $stable(st_reg.to_flag)) else $error("timeout flag moved");
  pcsp_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    pc_sp_reset |-> $past(wdog_overflow && low_power)) else $error("stray pc reset");
  pd_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && paddr == CMD_OFF && pwdata[CMD_CLRWDT_BIT] && !wdog_overflow |=> !st_reg.pd_flag)
    else $error("clear watchdog kept power-down");

endmodule : reset_cause_and_undervolt_ctrl

/* testbench/core_model.sv */
`timescale 1ns/10ps
module core_model (
  // Reset requests
  input wire logic clk,
  input wire logic sys_reset,
  input wire logic pc_sp_reset,
  input wire logic por_init,
  // Observed core state
  output logic [7:0] pc,
  output logic [7:0] port_dir,
  output logic [7:0] full_cnt,
  output logic [7:0] pcsp_cnt
);
  logic sys_q;
  always_ff @(posedge clk) begin
    sys_q <= sys_reset;
    if (sys_reset || pc_sp_reset) begin
      pc <= 8'h00;
    end else begin
      pc <= pc + 8'h01;
    end
    if (por_init) begin
      port_dir <= 8'hff;
      full_cnt <= 8'h00;
      pcsp_cnt <= 8'h00;
    end else begin
      if (sys_reset && !sys_q) begin
        full_cnt <= full_cnt + 8'h01;
      end
      if (pc_sp_reset) begin
        pcsp_cnt <= pcsp_cnt + 8'h01;
      end
    end
  end
endmodule : core_model

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import rst_ctrl_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, low_supply, wdog_overflow;
  logic sys_reset, pc_sp_reset, por_init, wdog_enable;
  logic [1:0] cpu_mode;
  logic [2:0] wdog_period;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pc, port_dir, full_cnt, pcsp_cnt, f0, p0;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [11:0] r_addr [5] = '{UVC_OFF, WDC_OFF, STS_OFF, 12'h020, 12'hffc};
  logic [31:0] r_exp [5] = '{32'h5a, 32'h57, 32'h0, 32'h0, 32'h0};
  reset_cause_and_undervolt_ctrl #(.FILTER_CYC(3), .FAULT_CYC(3)) u_reset_cause_and_undervolt_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_supply(low_supply), .wdog_overflow(wdog_overflow), .cpu_mode(cpu_mode),
    .sys_reset(sys_reset), .pc_sp_reset(pc_sp_reset), .por_init(por_init),
    .wdog_enable(wdog_enable), .wdog_period(wdog_period));
  core_model u_core_model (.clk(clk), .sys_reset(sys_reset), .pc_sp_reset(pc_sp_reset),
    .por_init(por_init), .pc(pc), .port_dir(port_dir), .full_cnt(full_cnt),
    .pcsp_cnt(pcsp_cnt));
  // ==========================================================================
  // Tasks
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Master holds the request until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rd_chk
  // Reset pulses start only after the filter and fault delays, so wait before polling.
  task settle;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 100 && sys_reset !== 1'b0; i++) @(posedge clk);
    f0 = full_cnt;
    p0 = pcsp_cnt;
  endtask : settle
  task low(input int n, input logic [1:0] m);
    @(posedge clk);
    low_supply <= 1'b1;
    cpu_mode <= m;
    repeat (n) @(posedge clk);
    low_supply <= 1'b0;
    cpu_mode <= MODE_FAST;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 100 && sys_reset !== 1'b0; i++) @(posedge clk);
  endtask : low
  task wd(input logic [1:0] m);
    @(posedge clk);
    cpu_mode <= m;
    wdog_overflow <= 1'b1;
    @(posedge clk);
    wdog_overflow <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 100 && sys_reset !== 1'b0; i++) @(posedge clk);
    cpu_mode <= MODE_FAST;
  endtask : wd
  // ==========================================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("ERROR %0t run exceeded its cycle limit", $time);
      wrap_up();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, low_supply, wdog_overflow} = 6'h00;
    cpu_mode = MODE_FAST;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check({24'h0, port_dir}, 32'hff);
    check({24'h0, full_cnt}, 32'h0);
    for (int i = 0; i < 5; i++) rd_chk(r_addr[i], r_exp[i]);
    apb(1'b0, RCF_OFF, 32'h0);
    check(rd & 32'hfffffffb, 32'h0);
    apb(1'b1, RCF_OFF, 32'h0);
    $display("reset values done");
    low(3, MODE_FAST);
    check({24'h0, full_cnt}, {24'h0, f0});
    low(8, MODE_FAST);
    check({24'h0, full_cnt}, {24'h0, f0 + 8'h01});
    rd_chk(RCF_OFF, 32'h4);
    rd_chk(UVC_OFF, 32'h5a);
    rd_chk(STS_OFF, 32'h0);
    apb(1'b1, RCF_OFF, 32'h0);
    rd_chk(RCF_OFF, 32'h0);
    settle();
    low(8, MODE_IDLE);
    low(8, MODE_SLEEP);
    apb(1'b1, UVC_OFF, 32'ha5);
    low(8, MODE_FAST);
    check({24'h0, full_cnt}, {24'h0, f0});
    rd_chk(UVC_OFF, 32'ha5);
    apb(1'b1, UVC_OFF, 32'h33);
    settle();
    rd_chk(UVC_OFF, 32'h5a);
    rd_chk(RCF_OFF, 32'h2);
    apb(1'b1, RCF_OFF, 32'h0);
    apb(1'b1, WDC_OFF, 32'hff);
    settle();
    rd_chk(RCF_OFF, 32'h1);
    $display("undervoltage and key tests done");
    wd(MODE_FAST);
    check({24'h0, full_cnt}, {24'h0, f0 + 8'h01});
    rd_chk(STS_OFF, 32'h1);
    settle();
    wd(MODE_IDLE);
    wd(MODE_SLEEP);
    check({16'h0, full_cnt, pcsp_cnt}, {16'h0, f0, p0 + 8'h02});
    rd_chk(STS_OFF, 32'h3);
    apb(1'b1, CMD_OFF, 32'h2);
    rd_chk(STS_OFF, 32'h1);
    apb(1'b1, CMD_OFF, 32'h1);
    rd_chk(STS_OFF, 32'h3);
    apb(1'b1, WDC_OFF, 32'haf);
    wd(MODE_FAST);
    check({31'h0, wdog_enable}, 32'h0);
    check({24'h0, full_cnt}, {24'h0, f0});
    apb(1'b1, WDC_OFF, 32'h57);
    @(posedge clk);
    check({31'h0, wdog_enable}, 32'h1);
    check({29'h0, wdog_period}, 32'h7);
    check({30'h0, pready, pslverr}, 32'h2);
    $display("watchdog tests done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({24'h0, pc}, 32'h0);
    check({31'h0, sys_reset}, 32'h1);
    rst_n <= 1'b1;
    settle();
    rd_chk(STS_OFF, 32'h0);
    rd_chk(RCF_OFF, 32'h0);
    check({24'h0, port_dir}, 32'hff);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule : testbench
